//--- wcrs_pkg.sv
package wcrs_pkg;

   // register byte addresses
   localparam int ADDR_W = 12;
   localparam logic [11:0] A_WAKE_RECORD = 12'h184;
   localparam logic [11:0] A_WAKE_ENABLE = 12'h188;
   localparam logic [11:0] A_INT_STATUS = 12'h190;
   localparam logic [11:0] A_INT_MASK = 12'h194;
   localparam logic [11:0] A_BUILD_OPTIONS = 12'h3F8;
   localparam logic [11:0] A_MODULE_IDENT = 12'h3FC;

   // wake sources: 0..6 gated by enable, 7 external interrupt, 8 timer
   localparam int WAKE_N_SRC = 9;
   localparam int WAKE_N_ASYNC = 7;
   localparam int WSRC_EXT_INT = 7;
   localparam int WSRC_TIMER = 8;
   localparam int WREC_EXT_INT_POS = 16;
   localparam int WREC_TIMER_POS = 17;
   localparam logic [31:0] WREC_RST = 32'h0000_0000;
   localparam logic [6:0] WAKE_EN_RST = 7'h00;

   // build option field positions
   localparam int BO_EVENT_CLK_POS = 7;
   localparam int BO_BRIDGE_LSB = 0;

   // identification fields; values are arbitrary
   localparam int ID_VERSION_LSB = 0;
   localparam int ID_VARIANT_LSB = 16;
   localparam logic [11:0] ID_VERSION_VAL = 12'h1A5;
   localparam logic [3:0] ID_VARIANT_VAL = 4'h0;

   // interrupt status / mask layout
   localparam int INT_W = 2;
   localparam int INT_WAKE = 0;
   localparam int INT_RESET = 1;
   localparam logic [1:0] INT_RST = 2'b00;

   // reset kinds, one bit each in reset_event
   localparam int RK_N = 8;
   localparam int RK_POWER_ON = 0;
   localparam int RK_PIN = 1;
   localparam int RK_WATCHDOG = 2;
   localparam int RK_BROWNOUT = 3;
   localparam int RK_SUPPLY_MON = 4;
   localparam int RK_CPU_ERROR = 5;
   localparam int RK_DEBUG = 6;
   localparam int RK_SCAN = 7;

   // which reset kinds clear each register group
   localparam logic [7:0] RS_POR_ONLY = 8'h01;
   localparam logic [7:0] RS_ALL = 8'hFF;
   localparam logic [7:0] RS_NOT_WATCHDOG = 8'hFB;
   localparam logic [7:0] RS_NOT_BROWNOUT = 8'hF7;
   localparam logic [7:0] RS_NOT_WDT_DEBUG = 8'hBB;

   typedef struct packed {
      logic async_timer_regs;
      logic osc32k;
      logic rc_calibration;
      logic voltage_calibration;
      logic other_osc_ctrl;
      logic clock_ctrl;
      logic supply_monitor_ctrl;
      logic core_logic;
      logic watchdog_ctrl;
      logic brownout_detector_ctrl;
      logic debug_system;
   } wcrs_scope_s;

   localparam wcrs_scope_s SCOPE_RST = '0;

   typedef enum logic {
      ST_AWAKE,
      ST_ASLEEP
   } wcrs_state_e;

endpackage

//--- wcrs_sync.sv
module wcrs_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

//--- wcrs_top.sv
module wcrs_top
   import wcrs_pkg::*;
#(
   parameter logic EVENT_CLK_PRESENT = 1'b1,
   parameter logic [3:0] BRIDGES_PRESENT = 4'hF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wake requests from peripherals (asynchronous)
   input wire logic [WAKE_N_SRC-1:0] wake_req_async,
   // sleep control
   input wire logic sleep_enter,
   output logic asleep,
   output logic wake_up,
   // reset events and group resets
   input wire logic [RK_N-1:0] reset_event,
   output wcrs_scope_s scope_reset,
   // interrupt
   output logic irq
);

   logic [WAKE_N_SRC-1:0] wake_req;
   logic [WAKE_N_SRC-1:0] wake_gated;
   logic wake_hit;
   logic any_reset;
   logic setup_ph;
   logic wr_en;
   logic [31:0] rd_word;
   logic rd_err;
   logic [1:0] int_clr;
   logic [1:0] int_set;

   wcrs_state_e state_q;
   wcrs_state_e state_d;
   logic [31:0] wake_record_q;
   logic [6:0] wake_en_q;
   logic [1:0] int_status_q;
   logic [1:0] int_mask_q;
   logic wake_up_q;
   wcrs_scope_s scope_q;
   wcrs_scope_s scope_d;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [31:0] wake_record_d;
   logic [6:0] wake_en_d;
   logic [1:0] int_mask_d;
   logic [1:0] int_status_d;
   logic [31:0] prdata_d;
   logic pslverr_d;
   logic hit_wake_enable;
   logic hit_int_status;
   logic hit_int_mask;

   // synchronise the wake request pins
   wcrs_sync #(
      .WIDTH(WAKE_N_SRC)
   ) u_wake_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(wake_req_async),
      .sync_out(wake_req)
   );

   // wake source gating
   always_comb begin
      wake_gated = wake_req;
      wake_gated[WAKE_N_ASYNC-1:0] = wake_req[WAKE_N_ASYNC-1:0] & wake_en_q;
   end

   assign wake_hit = (state_q == ST_ASLEEP) && (|wake_gated);

   // sleep state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_AWAKE: begin
            if (sleep_enter) begin
               state_d = ST_ASLEEP;
            end
         end
         ST_ASLEEP: begin
            if (wake_hit) begin
               state_d = ST_AWAKE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_AWAKE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_up_q <= 1'b0;
      end else begin
         wake_up_q <= wake_hit;
      end
   end

   // latest wake source record, replaced whole on each wake
   always_comb begin
      wake_record_d = wake_record_q;
      if (wake_hit) begin
         wake_record_d = WREC_RST;
         wake_record_d[WAKE_N_ASYNC-1:0] = wake_gated[WAKE_N_ASYNC-1:0];
         wake_record_d[WREC_EXT_INT_POS] = wake_gated[WSRC_EXT_INT];
         wake_record_d[WREC_TIMER_POS] = wake_gated[WSRC_TIMER];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_record_q <= WREC_RST;
      end else begin
         wake_record_q <= wake_record_d;
      end
   end

   // reset scope decode
   always_comb begin
      scope_d = SCOPE_RST;
      scope_d.async_timer_regs = |(reset_event & RS_POR_ONLY);
      scope_d.osc32k = |(reset_event & RS_POR_ONLY);
      scope_d.rc_calibration = |(reset_event & RS_POR_ONLY);
      scope_d.voltage_calibration = |(reset_event & RS_POR_ONLY);
      scope_d.other_osc_ctrl = |(reset_event & RS_ALL);
      scope_d.clock_ctrl = |(reset_event & RS_ALL);
      scope_d.supply_monitor_ctrl = |(reset_event & RS_ALL);
      scope_d.core_logic = |(reset_event & RS_ALL);
      scope_d.watchdog_ctrl = |(reset_event & RS_NOT_WATCHDOG);
      scope_d.debug_system = |(reset_event & RS_NOT_WDT_DEBUG);
      scope_d.brownout_detector_ctrl = |(reset_event & RS_NOT_BROWNOUT);
   end

   assign any_reset = |reset_event;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scope_q <= SCOPE_RST;
      end else begin
         scope_q <= scope_d;
      end
   end

   // apb decode
   assign setup_ph = psel && !penable;
   assign wr_en = psel && penable && pwrite;

   // write strobes per register; only byte 0 carries fields
   assign hit_wake_enable = wr_en && (paddr == A_WAKE_ENABLE) && pstrb[0];
   assign hit_int_status = wr_en && (paddr == A_INT_STATUS) && pstrb[0];
   assign hit_int_mask = wr_en && (paddr == A_INT_MASK) && pstrb[0];

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      unique case (paddr)
         A_WAKE_RECORD: begin
            rd_word = wake_record_q;
         end
         A_WAKE_ENABLE: begin
            rd_word[WAKE_N_ASYNC-1:0] = wake_en_q;
         end
         A_INT_STATUS: begin
            rd_word[INT_W-1:0] = int_status_q;
         end
         A_INT_MASK: begin
            rd_word[INT_W-1:0] = int_mask_q;
         end
         A_BUILD_OPTIONS: begin
            rd_word[BO_EVENT_CLK_POS] = EVENT_CLK_PRESENT;
            rd_word[BO_BRIDGE_LSB +: 4] = BRIDGES_PRESENT;
         end
         A_MODULE_IDENT: begin
            rd_word[ID_VERSION_LSB +: 12] = ID_VERSION_VAL;
            rd_word[ID_VARIANT_LSB +: 4] = ID_VARIANT_VAL;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // read data and error are captured in the setup cycle
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (setup_ph) begin
         prdata_d = pwrite ? 32'h0000_0000 : rd_word;
         pslverr_d = rd_err;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // wake enable register
   always_comb begin
      wake_en_d = wake_en_q;
      if (hit_wake_enable) begin
         wake_en_d = pwdata[WAKE_N_ASYNC-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_en_q <= WAKE_EN_RST;
      end else begin
         wake_en_q <= wake_en_d;
      end
   end

   // interrupt mask register
   always_comb begin
      int_mask_d = int_mask_q;
      if (hit_int_mask) begin
         int_mask_d = pwdata[INT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_q <= INT_RST;
      end else begin
         int_mask_q <= int_mask_d;
      end
   end

   // sticky status, write one to clear; a new event wins over a clear
   always_comb begin
      int_clr = '0;
      if (hit_int_status) begin
         int_clr = pwdata[INT_W-1:0];
      end
      int_set = '0;
      int_set[INT_WAKE] = wake_hit;
      int_set[INT_RESET] = any_reset;
      int_status_d = (int_status_q & ~int_clr) | int_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_q <= INT_RST;
      end else begin
         int_status_q <= int_status_d;
      end
   end

   // outputs
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;
   assign pready = 1'b1;
   assign asleep = (state_q == ST_ASLEEP);
   assign wake_up = wake_up_q;
   assign scope_reset = scope_q;
   assign irq = |(int_status_q & int_mask_q);

endmodule

//--- wcrs_monitor.sv
module wcrs_monitor
   import wcrs_pkg::*;
#(
   parameter logic EVENT_CLK_PRESENT = 1'b1,
   parameter logic [3:0] BRIDGES_PRESENT = 4'hF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   // wake and reset scope
   input wire logic asleep,
   input wire logic wake_up,
   input wire logic [RK_N-1:0] reset_event,
   input wire wcrs_scope_s scope_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_setup;
   assign rd_setup = psel && !penable && !pwrite;

   chk_por_groups:
      assert property (scope_reset[10:7] == {4{$past(reset_event[0])}})
      else $error("power-on-only groups wrong");
   chk_all_groups:
      assert property (scope_reset[6:3] == {4{|$past(reset_event)}})
      else $error("every-reset groups wrong");
   chk_watchdog_keep:
      assert property (scope_reset[2] == |($past(reset_event) & 8'hFB)
         && scope_reset[0] == |($past(reset_event) & 8'hBB))
      else $error("watchdog or debug scope wrong");
   chk_brownout_keep:
      assert property (scope_reset[1] == |($past(reset_event) & 8'hF7))
      else $error("brownout scope wrong");
   chk_wake_pulse:
      assert property ($fell(asleep) |-> wake_up ##1 !wake_up)
      else $error("wake pulse wrong");
   chk_ident_read:
      assert property (rd_setup && paddr == A_MODULE_IDENT
         |=> prdata == {12'h000, ID_VARIANT_VAL, 4'h0, ID_VERSION_VAL})
      else $error("ident read wrong");
   chk_options_read:
      assert property (rd_setup && paddr == A_BUILD_OPTIONS
         |=> prdata == {24'h0, EVENT_CLK_PRESENT, 3'h0, BRIDGES_PRESENT})
      else $error("options read wrong");
   chk_record_unused:
      assert property (rd_setup && paddr == A_WAKE_RECORD
         |=> prdata[31:18] == '0 && prdata[15:7] == '0)
      else $error("record unused bits set");
endmodule

bind wcrs_top wcrs_monitor #(
   .EVENT_CLK_PRESENT(EVENT_CLK_PRESENT),
   .BRIDGES_PRESENT(BRIDGES_PRESENT)
) mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .asleep(asleep), .wake_up(wake_up),
   .reset_event(reset_event), .scope_reset(scope_reset));

//--- wcrs_wake_src.sv
module wcrs_wake_src
   import wcrs_pkg::*;
(
   // clock
   input wire logic pclk,
   // requests
   output logic [WAKE_N_SRC-1:0] wake_req_async,
   output logic [RK_N-1:0] reset_event
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wake_req_async = '0;
      reset_event = '0;
   end
   // wake lines rise off the clock edge, after a chosen lag
   task automatic raise(input int i, input int lag);
      #(lag);
      wake_req_async[i] <= 1'b1;
   endtask
   task automatic drop();
      wake_req_async <= '0;
   endtask
   // one-cycle reset source pulse
   task automatic fire(input logic [RK_N-1:0] k);
      @(posedge pclk);
      reset_event <= k;
      @(posedge pclk);
      reset_event <= '0;
   endtask
endmodule

//--- test_wake_cause_and_reset_scope.sv
module test_wake_cause_and_reset_scope
   import wcrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_enter = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, asleep, wake_up, irq, er;
   logic [8:0] wake_req_async;
   logic [7:0] reset_event;
   wcrs_scope_s scope_reset;
   int n_fail = 0, samples_checked = 0, cyc = 0;

   initial forever #12.5 pclk = ~pclk;

   wcrs_top #(.EVENT_CLK_PRESENT(1'b0), .BRIDGES_PRESENT(4'hA)) uut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake_req_async(wake_req_async), .sleep_enter(sleep_enter), .asleep(asleep),
      .wake_up(wake_up), .reset_event(reset_event), .scope_reset(scope_reset), .irq(irq));
   wcrs_wake_src src (.pclk(pclk), .wake_req_async(wake_req_async),
      .reset_event(reset_event));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, '0);
      chk(n, e, r);
   endtask
   task automatic sleep_wake(input int i, input logic exp);
      int n;
      sleep_enter <= 1'b1;
      tick(1);
      sleep_enter <= 1'b0;
      tick(1);
      src.raise(i, 3 + 2 * i);
      n = 0;
      while (wake_up !== 1'b1 && n < 8) begin
         @(posedge pclk);
         n++;
      end
      chk("wake_up", exp, wake_up);
      src.drop();
      tick(4);
   endtask

   task automatic t_regs();
      rd(A_WAKE_RECORD, '0, "record");
      rd(A_WAKE_ENABLE, '0, "enable");
      rd(A_BUILD_OPTIONS, 32'h0000000A, "options");
      apb(1'b1, A_MODULE_IDENT, '1);
      rd(A_MODULE_IDENT, {12'h000, ID_VARIANT_VAL, 4'h0, ID_VERSION_VAL}, "ident");
      apb(1'b1, A_WAKE_ENABLE, '1);
      rd(A_WAKE_ENABLE, 32'h0000007F, "enable");
      apb(1'b0, 12'h200, '0);
      chk("unmapped error", 1, er);
      $display("t_regs done");
   endtask
   task automatic t_wake();
      for (int i = 0; i < WAKE_N_SRC; i++) begin
         sleep_wake(i, 1'b1);
         rd(A_WAKE_RECORD, i < 7 ? 32'h1 << i : 32'h1 << (i + 9), "record");
      end
      apb(1'b1, A_WAKE_ENABLE, 32'h0000007B);
      sleep_wake(2, 1'b0);
      chk("asleep", 1, asleep);
      sleep_wake(WSRC_EXT_INT, 1'b1);
      rd(A_WAKE_RECORD, 32'h1 << WREC_EXT_INT_POS, "record");
      $display("t_wake done");
   endtask
   task automatic t_reset();
      for (int k = 0; k < RK_N; k++) src.fire(8'h01 << k);
      src.fire(8'h44);
      tick(2);
      rd(A_INT_STATUS, 32'h3, "status");
      $display("t_reset done");
   endtask
   task automatic t_irq();
      apb(1'b1, A_INT_MASK, 32'h1);
      tick(1);
      chk("irq", 1, irq);
      apb(1'b1, A_INT_STATUS, 32'h1);
      tick(1);
      chk("irq", 0, irq);
      apb(1'b1, A_INT_MASK, 32'h2);
      tick(1);
      chk("irq", 1, irq);
      apb(1'b1, A_INT_STATUS, 32'h2);
      tick(1);
      chk("irq", 0, irq);
      rd(A_INT_STATUS, '0, "status");
      $display("t_irq done");
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_wake();
      t_reset();
      t_irq();
      print_verdict();
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
endmodule
